/* clock_synth_scratch_ddc_pkg.sv */
package clock_synth_scratch_ddc_pkg;

   // ****************************************************************
   // i/o ports of the index/data pair
   // ****************************************************************
   localparam logic [15:0] INDEX_PORT_ADDR = 16'h03c4;
   localparam logic [15:0] DATA_PORT_ADDR  = 16'h03c5;

   // ****************************************************************
   // register indices
   // ****************************************************************
   localparam logic [7:0] IDX_MEMORY_CLOCK_NUMERATOR           = 8'h6a;
   localparam logic [7:0] IDX_MEMORY_CLOCK_DENOMINATOR         = 8'h6b;
   localparam logic [7:0] IDX_VIDEO_CLOCK_NUMERATOR            = 8'h6c;
   localparam logic [7:0] IDX_VIDEO_CLOCK_DENOMINATOR_POSTDIV  = 8'h6d;
   localparam logic [7:0] IDX_SECOND_VIDEO_CLOCK_NUMERATOR     = 8'h6e;
   localparam logic [7:0] IDX_SECOND_VIDEO_CLOCK_DENOMINATOR   = 8'h6f;
   localparam logic [7:0] IDX_SCRATCH_PAD_STRAPPED             = 8'h70;
   localparam logic [7:0] IDX_SCRATCH_PAD_GENERAL              = 8'h71;
   localparam logic [7:0] IDX_TWO_WIRE_PORT_CONTROL            = 8'h72;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RST_MEMORY_CLOCK_NUMERATOR          = 8'h5a;
   localparam logic [7:0] RST_MEMORY_CLOCK_DENOMINATOR        = 8'h20;
   localparam logic [7:0] RST_VIDEO_CLOCK_NUMERATOR           = 8'h5b;
   localparam logic [7:0] RST_VIDEO_CLOCK_DENOMINATOR_POSTDIV = 8'h2e;
   localparam logic [7:0] RST_SECOND_VIDEO_CLOCK_NUMERATOR    = 8'h5a;
   localparam logic [7:0] RST_SECOND_VIDEO_CLOCK_DENOMINATOR  = 8'h20;
   localparam logic [7:0] RST_SCRATCH_PAD                     = 8'h00;
   localparam logic [7:0] RST_TWO_WIRE_PORT_CONTROL           = 8'h00;
   localparam logic [7:0] RST_INDEX                           = 8'h00;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int DEN_MSB             = 5;
   localparam int POSTDIV_HALF_BIT    = 7;
   localparam int POSTDIV_QUARTER_BIT = 6;
   localparam int STRAP_MSB           = 3;
   localparam int DATA_LINE_ENABLE    = 5;
   localparam int CLOCK_LINE_ENABLE   = 4;
   localparam int DATA_LINE_STATE     = 3;
   localparam int CLOCK_LINE_STATE    = 2;
   localparam int DATA_LINE_DRIVE     = 1;
   localparam int CLOCK_LINE_DRIVE    = 0;

   // ****************************************************************
   // clock control source select
   // ****************************************************************
   localparam logic [1:0] SOURCE_SELECT_PROGRAMMED = 2'h1;

   // ****************************************************************
   // post-divider shift codes (divide by 2**shift)
   // ****************************************************************
   localparam logic [1:0] SHIFT_DIV1 = 2'h0;
   localparam logic [1:0] SHIFT_DIV2 = 2'h1;
   localparam logic [1:0] SHIFT_DIV4 = 2'h2;
   localparam logic [1:0] SHIFT_DIV8 = 2'h3;

   localparam int REFERENCE_KHZ = 14318;

endpackage

/* clock_synth_scratch_ddc_regs.sv */
`timescale 1ns/1ps
// What this block does
// - registers at indices 6ah..72h, index written first, data through port 3c5h, read/write
// - memory clock numerator holds eight bits, resets to 5ah
// - memory clock denominator holds bits 5:0, bits 7:6 reserved, resets to 20h
// - memory clock is reference times numerator over denominator
// - video clock numerator holds eight bits, resets to 5bh
// - video clock denominator in bits 5:0, register resets to 2eh, post-divider zero
// - video clock is reference times numerator over denominator, then post-divided
// - post-divider 00 none, bit7 alone half, bit6 alone quarter, both eighth
// - quarter and eighth only when a source select bit is set
// - second video clock numerator holds eight bits, resets to 5ah
// - second video clock denominator in bits 5:0, bits 7:6 reserved, resets 20h
// - first scratch low nibble captured from memory data pins on the first enabled edge after reset
// - second scratch register is eight plain read/write bits
// - two-wire port register resets to 00h, bits 7:6 reserved
// - enabled drive bit 0 pulls pin low, 1 releases it
// - programmed video settings act only with select 01 and source enable set
module clock_synth_scratch_ddc_regs #(
   parameter int IO_ADDR_WIDTH = 16,
   parameter int DATA_WIDTH    = 8
) (
   // clock, reset, enable
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     ce_in,
   // host i/o port
   input  wire logic [IO_ADDR_WIDTH-1:0] io_addr_in,
   input  wire logic                     io_wr_in,
   input  wire logic                     io_rd_in,
   input  wire logic [DATA_WIDTH-1:0]    io_wdata_in,
   output logic      [DATA_WIDTH-1:0]    io_rdata_out,
   output logic                          io_rdata_valid_out,
   // clock control from the neighbouring register
   input  wire logic [1:0]               clock_source_select_in,
   input  wire logic                     clock_source_enable_in,
   // power-on straps
   input  wire logic [3:0]               memory_data_pins_in,
   // synthesizer settings
   output logic      [7:0]               memory_clock_numerator_value_out,
   output logic      [5:0]               memory_clock_denominator_value_out,
   output logic      [7:0]               video_clock_numerator_value_out,
   output logic      [5:0]               video_clock_denominator_value_out,
   output logic      [1:0]               video_post_divide_shift_out,
   output logic                          video_clock_programmed_out,
   output logic      [7:0]               second_video_numerator_value_out,
   output logic      [5:0]               second_video_denominator_value_out,
   // two-wire pins, open drain
   input  wire logic                     user_data_pin_in,
   output logic                          user_data_pin_out,
   output logic                          user_data_pin_oe_n_out,
   input  wire logic                     user_clock_pin_in,
   output logic                          user_clock_pin_out,
   output logic                          user_clock_pin_oe_n_out
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (DATA_WIDTH != 8) begin : g_bad_width
      $error("data width must be 8");
   end
   if (IO_ADDR_WIDTH < 10 || IO_ADDR_WIDTH > 16) begin : g_bad_addr
      $error("i/o address width must be 10 to 16");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [7:0] index;
      logic [7:0] mclk_num;
      logic [5:0] mclk_den;
      logic [7:0] vclk_num;
      logic [1:0] post_divider;
      logic [5:0] vclk_den;
      logic [7:0] second_video_clock_num;
      logic [5:0] second_video_clock_den;
      logic [7:0] scratch_strapped;
      logic [7:0] scratch_general;
      logic       data_line_port_enable;
      logic       clock_line_port_enable;
      logic       data_line_drive;
      logic       clock_line_drive;
      logic       strap_done;
      logic [1:0] post_shift;
      logic       vclk_programmed;
      logic [7:0] rdata;
      logic       rd_valid;
   } state_type;

   state_type state_reg;
   state_type state_next;

   logic [15:0] addr_ext;
   logic        index_wr;
   logic        index_rd;
   logic        data_wr;
   logic        data_rd;
   logic [7:0]  read_mux;
   logic        data_line_pulled;
   logic        clock_line_pulled;

   assign addr_ext = 16'(io_addr_in);
   assign index_wr = io_wr_in && (addr_ext == clock_synth_scratch_ddc_pkg::INDEX_PORT_ADDR);
   assign index_rd = io_rd_in && (addr_ext == clock_synth_scratch_ddc_pkg::INDEX_PORT_ADDR);
   assign data_wr  = io_wr_in && (addr_ext == clock_synth_scratch_ddc_pkg::DATA_PORT_ADDR);
   assign data_rd  = io_rd_in && (addr_ext == clock_synth_scratch_ddc_pkg::DATA_PORT_ADDR);

   // ****************************************************************
   // read data
   // ****************************************************************
   // indices outside this group belong to other banks; they read zero here
   always_comb begin
      read_mux = 8'h00;
      unique case (state_reg.index)
         clock_synth_scratch_ddc_pkg::IDX_MEMORY_CLOCK_NUMERATOR:
            read_mux = state_reg.mclk_num;
         clock_synth_scratch_ddc_pkg::IDX_MEMORY_CLOCK_DENOMINATOR:
            read_mux = {2'h0, state_reg.mclk_den};
         clock_synth_scratch_ddc_pkg::IDX_VIDEO_CLOCK_NUMERATOR:
            read_mux = state_reg.vclk_num;
         clock_synth_scratch_ddc_pkg::IDX_VIDEO_CLOCK_DENOMINATOR_POSTDIV:
            read_mux = {state_reg.post_divider, state_reg.vclk_den};
         clock_synth_scratch_ddc_pkg::IDX_SECOND_VIDEO_CLOCK_NUMERATOR:
            read_mux = state_reg.second_video_clock_num;
         clock_synth_scratch_ddc_pkg::IDX_SECOND_VIDEO_CLOCK_DENOMINATOR:
            read_mux = {2'h0, state_reg.second_video_clock_den};
         clock_synth_scratch_ddc_pkg::IDX_SCRATCH_PAD_STRAPPED:
            read_mux = state_reg.scratch_strapped;
         clock_synth_scratch_ddc_pkg::IDX_SCRATCH_PAD_GENERAL:
            read_mux = state_reg.scratch_general;
         clock_synth_scratch_ddc_pkg::IDX_TWO_WIRE_PORT_CONTROL:
            read_mux = {2'h0, state_reg.data_line_port_enable, state_reg.clock_line_port_enable,
                        user_data_pin_in, user_clock_pin_in,
                        state_reg.data_line_drive, state_reg.clock_line_drive};
         default:
            read_mux = 8'h00;
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      state_next.rd_valid = 1'b0;
      // straps are taken on the first enabled edge after reset release
      if (!state_reg.strap_done) begin
         state_next.scratch_strapped[clock_synth_scratch_ddc_pkg::STRAP_MSB:0] =
            memory_data_pins_in;
         state_next.strap_done = 1'b1;
      end
      if (index_wr) begin
         state_next.index = io_wdata_in;
      end
      if (index_rd) begin
         state_next.rdata    = state_reg.index;
         state_next.rd_valid = 1'b1;
      end
      if (data_rd) begin
         state_next.rdata    = read_mux;
         state_next.rd_valid = 1'b1;
      end
      if (data_wr) begin
         unique case (state_reg.index)
            clock_synth_scratch_ddc_pkg::IDX_MEMORY_CLOCK_NUMERATOR:
               state_next.mclk_num = io_wdata_in;
            clock_synth_scratch_ddc_pkg::IDX_MEMORY_CLOCK_DENOMINATOR:
               state_next.mclk_den = io_wdata_in[clock_synth_scratch_ddc_pkg::DEN_MSB:0];
            clock_synth_scratch_ddc_pkg::IDX_VIDEO_CLOCK_NUMERATOR:
               state_next.vclk_num = io_wdata_in;
            clock_synth_scratch_ddc_pkg::IDX_VIDEO_CLOCK_DENOMINATOR_POSTDIV: begin
               state_next.vclk_den     = io_wdata_in[clock_synth_scratch_ddc_pkg::DEN_MSB:0];
               state_next.post_divider = io_wdata_in[7:6];
            end
            clock_synth_scratch_ddc_pkg::IDX_SECOND_VIDEO_CLOCK_NUMERATOR:
               state_next.second_video_clock_num = io_wdata_in;
            clock_synth_scratch_ddc_pkg::IDX_SECOND_VIDEO_CLOCK_DENOMINATOR:
               state_next.second_video_clock_den = io_wdata_in[clock_synth_scratch_ddc_pkg::DEN_MSB:0];
            clock_synth_scratch_ddc_pkg::IDX_SCRATCH_PAD_STRAPPED:
               state_next.scratch_strapped = io_wdata_in;
            clock_synth_scratch_ddc_pkg::IDX_SCRATCH_PAD_GENERAL:
               state_next.scratch_general = io_wdata_in;
            clock_synth_scratch_ddc_pkg::IDX_TWO_WIRE_PORT_CONTROL: begin
               // status bits and bits 7:6 are not stored
               state_next.data_line_port_enable =
                  io_wdata_in[clock_synth_scratch_ddc_pkg::DATA_LINE_ENABLE];
               state_next.clock_line_port_enable =
                  io_wdata_in[clock_synth_scratch_ddc_pkg::CLOCK_LINE_ENABLE];
               state_next.data_line_drive  = io_wdata_in[clock_synth_scratch_ddc_pkg::DATA_LINE_DRIVE];
               state_next.clock_line_drive = io_wdata_in[clock_synth_scratch_ddc_pkg::CLOCK_LINE_DRIVE];
            end
            default: begin
            end
         endcase
      end
      // post-divider: bit 7 halves, bit 6 quarters; bit 6 needs a source select bit
      if (clock_source_select_in != 2'h0) begin
         unique case ({state_reg.post_divider[0], state_reg.post_divider[1]})
            2'h0:    state_next.post_shift = clock_synth_scratch_ddc_pkg::SHIFT_DIV1;
            2'h1:    state_next.post_shift = clock_synth_scratch_ddc_pkg::SHIFT_DIV2;
            2'h2:    state_next.post_shift = clock_synth_scratch_ddc_pkg::SHIFT_DIV4;
            default: state_next.post_shift = clock_synth_scratch_ddc_pkg::SHIFT_DIV8;
         endcase
      end else begin
         // quarter and eighth are not available; bit 7 alone still halves
         state_next.post_shift = state_reg.post_divider[1] ?
                                 clock_synth_scratch_ddc_pkg::SHIFT_DIV2 :
                                 clock_synth_scratch_ddc_pkg::SHIFT_DIV1;
      end
      state_next.vclk_programmed = clock_source_enable_in &&
         (clock_source_select_in == clock_synth_scratch_ddc_pkg::SOURCE_SELECT_PROGRAMMED);
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg.index                  <= clock_synth_scratch_ddc_pkg::RST_INDEX;
         state_reg.mclk_num               <= clock_synth_scratch_ddc_pkg::RST_MEMORY_CLOCK_NUMERATOR;
         state_reg.mclk_den               <= clock_synth_scratch_ddc_pkg::RST_MEMORY_CLOCK_DENOMINATOR[5:0];
         state_reg.vclk_num               <= clock_synth_scratch_ddc_pkg::RST_VIDEO_CLOCK_NUMERATOR;
         state_reg.post_divider           <=
            clock_synth_scratch_ddc_pkg::RST_VIDEO_CLOCK_DENOMINATOR_POSTDIV[7:6];
         state_reg.vclk_den               <=
            clock_synth_scratch_ddc_pkg::RST_VIDEO_CLOCK_DENOMINATOR_POSTDIV[5:0];
         state_reg.second_video_clock_num              <= clock_synth_scratch_ddc_pkg::RST_SECOND_VIDEO_CLOCK_NUMERATOR;
         state_reg.second_video_clock_den              <=
            clock_synth_scratch_ddc_pkg::RST_SECOND_VIDEO_CLOCK_DENOMINATOR[5:0];
         state_reg.scratch_strapped       <= clock_synth_scratch_ddc_pkg::RST_SCRATCH_PAD;
         state_reg.scratch_general        <= clock_synth_scratch_ddc_pkg::RST_SCRATCH_PAD;
         state_reg.data_line_port_enable  <= clock_synth_scratch_ddc_pkg::RST_TWO_WIRE_PORT_CONTROL[5];
         state_reg.clock_line_port_enable <= clock_synth_scratch_ddc_pkg::RST_TWO_WIRE_PORT_CONTROL[4];
         state_reg.data_line_drive        <= clock_synth_scratch_ddc_pkg::RST_TWO_WIRE_PORT_CONTROL[1];
         state_reg.clock_line_drive       <= clock_synth_scratch_ddc_pkg::RST_TWO_WIRE_PORT_CONTROL[0];
         state_reg.strap_done             <= 1'b0;
         state_reg.post_shift             <= clock_synth_scratch_ddc_pkg::SHIFT_DIV1;
         state_reg.vclk_programmed        <= 1'b0;
         state_reg.rdata                  <= 8'h00;
         state_reg.rd_valid               <= 1'b0;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // frequency = reference * num / den / 2**shift is formed by the analog synthesizer
   assign memory_clock_numerator_value_out   = state_reg.mclk_num;
   assign memory_clock_denominator_value_out = state_reg.mclk_den;
   assign video_clock_numerator_value_out    = state_reg.vclk_num;
   assign video_clock_denominator_value_out  = state_reg.vclk_den;
   assign video_post_divide_shift_out        = state_reg.post_shift;
   assign video_clock_programmed_out         = state_reg.vclk_programmed;
   assign second_video_numerator_value_out   = state_reg.second_video_clock_num;
   assign second_video_denominator_value_out = state_reg.second_video_clock_den;
   assign io_rdata_out                       = state_reg.rdata;
   assign io_rdata_valid_out                 = state_reg.rd_valid;

   // open drain: the pin only ever sinks, so the data level is a constant low
   assign data_line_pulled        = state_reg.data_line_port_enable && !state_reg.data_line_drive;
   assign clock_line_pulled       = state_reg.clock_line_port_enable && !state_reg.clock_line_drive;
   assign user_data_pin_out       = 1'b0;
   assign user_clock_pin_out      = 1'b0;
   assign user_data_pin_oe_n_out  = !data_line_pulled;
   assign user_clock_pin_oe_n_out = !clock_line_pulled;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_data_write(logic [7:0] idx);
      ce_in && data_wr && (state_reg.index == idx);
   endsequence

   sequence s_data_read(logic [7:0] idx);
      ce_in && data_rd && !data_wr && (state_reg.index == idx);
   endsequence

   a_mclk_num_write: assert property (
      s_data_write(clock_synth_scratch_ddc_pkg::IDX_MEMORY_CLOCK_NUMERATOR) |=>
         memory_clock_numerator_value_out == $past(io_wdata_in))
      else $error("memory clock numerator not stored");

   a_mclk_den_reserved: assert property (
      s_data_read(clock_synth_scratch_ddc_pkg::IDX_MEMORY_CLOCK_DENOMINATOR) |=>
         io_rdata_valid_out && io_rdata_out[7:6] == 2'h0 && io_rdata_out[5:0] == memory_clock_denominator_value_out)
      else $error("memory clock denominator readback wrong");

   a_vclk_num_write: assert property (
      s_data_write(clock_synth_scratch_ddc_pkg::IDX_VIDEO_CLOCK_NUMERATOR) ##1 s_data_read(
         clock_synth_scratch_ddc_pkg::IDX_VIDEO_CLOCK_NUMERATOR) |=> io_rdata_out == $past(io_wdata_in, 2))
      else $error("video clock numerator readback wrong");

   a_quarter_needs_select: assert property (
      ce_in && clock_source_select_in == 2'h0 |=>
         video_post_divide_shift_out <= clock_synth_scratch_ddc_pkg::SHIFT_DIV2)
      else $error("quarter or eighth division without source select");

   a_post_div_eighth: assert property (
      ce_in && clock_source_select_in != 2'h0 && $past(ce_in) && video_post_divide_shift_out != 2'h3 ##0
         (state_reg.post_divider == 2'h3) |=> video_post_divide_shift_out == clock_synth_scratch_ddc_pkg::SHIFT_DIV8)
      else $error("post-divider eighth not applied");

   a_vclk_programmed: assert property (
      ce_in |=> video_clock_programmed_out == ($past(clock_source_enable_in) &&
         $past(clock_source_select_in) == clock_synth_scratch_ddc_pkg::SOURCE_SELECT_PROGRAMMED))
      else $error("programmed video clock flag wrong");

   a_strap_capture: assert property (
      $rose(state_reg.strap_done) |-> state_reg.scratch_strapped[3:0] == $past(memory_data_pins_in))
      else $error("strap nibble not captured");

   a_pin_disabled: assert property (
      (state_reg.data_line_port_enable || user_data_pin_oe_n_out) &&
         (state_reg.clock_line_port_enable || user_clock_pin_oe_n_out))
      else $error("pin driven while its port is disabled");

   a_pin_drive_low: assert property (
      s_data_write(clock_synth_scratch_ddc_pkg::IDX_TWO_WIRE_PORT_CONTROL) ##0 (io_wdata_in[5] && !io_wdata_in[1])
         |=> !user_data_pin_oe_n_out && !user_data_pin_out)
      else $error("enabled data line not pulled low");

   a_pin_status: assert property (
      s_data_read(clock_synth_scratch_ddc_pkg::IDX_TWO_WIRE_PORT_CONTROL) |=>
         io_rdata_out[3] == $past(user_data_pin_in) && io_rdata_out[2] == $past(user_clock_pin_in)
         && io_rdata_out[7:6] == 2'h0)
      else $error("two-wire status readback wrong");

   a_scratch_general: assert property (
      s_data_write(clock_synth_scratch_ddc_pkg::IDX_SCRATCH_PAD_GENERAL) ##1 s_data_read(
         clock_synth_scratch_ddc_pkg::IDX_SCRATCH_PAD_GENERAL) |=> io_rdata_out == $past(io_wdata_in, 2))
      else $error("general scratch readback wrong");

endmodule

/* two_wire_monitor_model.sv */
`timescale 1ns/1ps
// monitor side of the two-wire port; bus pull-ups hold released lines high
module two_wire_monitor_model (
   input  wire logic data_oe_n_in,
   input  wire logic clock_oe_n_in,
   input  wire logic data_hold_low_in,
   output logic      data_pin_out,
   output logic      clock_pin_out
);
   assign data_pin_out  = data_oe_n_in & ~data_hold_low_in;
   assign clock_pin_out = clock_oe_n_in;
endmodule

/* clock_synth_scratch_ddc_regs_tb_top.sv */
`timescale 1ns/1ps
module clock_synth_scratch_ddc_regs_tb_top;
   logic clk_in = 0, rst_in = 1, wr = 0, rd = 0, hold = 0, en = 0, ce = 1, vld, doe, coe, dpin, cpin, pg, dout, cout;
   logic [15:0] addr = 0;
   logic [7:0]  wd = 0, rdat, mn, vn, sn, d, so, q[$];
   logic [5:0]  md, vd, sd;
   logic [3:0]  strap = 0;
   logic [1:0]  sel = 0, sh, ex;
   int          num_errors = 0, n_compared = 0;
   always #5 clk_in = ~clk_in;
   clock_synth_scratch_ddc_regs dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .io_addr_in(addr),
      .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wd), .io_rdata_out(rdat), .io_rdata_valid_out(vld),
      .clock_source_select_in(sel), .clock_source_enable_in(en), .memory_data_pins_in(strap),
      .memory_clock_numerator_value_out(mn), .memory_clock_denominator_value_out(md),
      .video_clock_numerator_value_out(vn), .video_clock_denominator_value_out(vd),
      .video_post_divide_shift_out(sh), .video_clock_programmed_out(pg),
      .second_video_numerator_value_out(sn), .second_video_denominator_value_out(sd),
      .user_data_pin_in(dpin), .user_data_pin_out(dout), .user_data_pin_oe_n_out(doe),
      .user_clock_pin_in(cpin), .user_clock_pin_out(cout), .user_clock_pin_oe_n_out(coe));
   two_wire_monitor_model mon (.data_oe_n_in(doe), .clock_oe_n_in(coe), .data_hold_low_in(hold),
      .data_pin_out(dpin), .clock_pin_out(cpin));
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // index write, then one data write or read; strobes held for exactly one edge
   task automatic acc(input logic [7:0] idx, input logic [7:0] dat, input logic is_rd);
      @(negedge clk_in) {wr, rd, addr, wd} = {2'b10, 16'h03c4, idx};
      @(negedge clk_in) {wr, rd, addr, wd} = {~is_rd, is_rd, 16'h03c5, dat};
      @(negedge clk_in) {wr, rd} = 2'b00;
   endtask
   task automatic rdx(input logic [7:0] idx, input logic [7:0] e);
      q.push_back(e);
      acc(idx, 8'h00, 1'b1);
   endtask
   // write, read straight back with no new index, then read the index port itself
   task automatic wrrd(input logic [7:0] idx, input logic [7:0] dat, input logic [7:0] e);
      q.push_back(e);
      q.push_back(idx);
      @(negedge clk_in) {wr, rd, addr, wd} = {2'b10, 16'h03c4, idx};
      @(negedge clk_in) {wr, rd, addr, wd} = {2'b10, 16'h03c5, dat};
      @(negedge clk_in) {wr, rd} = 2'b01;
      @(negedge clk_in) addr = 16'h03c4;
      @(negedge clk_in) {wr, rd} = 2'b00;
   endtask
   always @(negedge clk_in) if (vld === 1'b1) begin
      if (q.size() == 0) chk("unexpected read", rdat, 8'hxx);
      else chk("read data", rdat, q.pop_front());
   end
   initial begin
      #200000 num_errors++;
      complete_run;
   end
   initial begin
      void'($urandom(32'h8832));
      strap = 4'($urandom());
      repeat (2) @(negedge clk_in);
      rst_in = 0;
      rdx(8'h6a, 8'h5a); rdx(8'h6b, 8'h20); rdx(8'h6c, 8'h5b); rdx(8'h6d, 8'h2e);
      rdx(8'h6e, 8'h5a); rdx(8'h6f, 8'h20); rdx(8'h72, 8'h0c); rdx(8'h70, {4'h0, strap});
      // let the last read pulse clear before freezing, or it would stand while enable is low
      @(negedge clk_in) ce = 0;
      acc(8'h6e, 8'ha5, 1'b0);
      ce = 1;
      chk("frozen write", sn, 8'h5a);
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom());
         wrrd(8'(8'h6a + i), d, (i == 1 || i == 5) ? d & 8'h3f : d);
         so = (i == 0) ? mn : (i == 1) ? {2'h0, md} : (i == 2) ? vn : (i == 3) ? {2'h0, vd} : (i == 4) ? sn : {2'h0, sd};
         if (i < 6) chk("setting out", so, (i % 2 == 1) ? d & 8'h3f : d);
      end
      rdx(8'h73, 8'h00);
      acc(8'h72, 8'hc0, 1'b0); chk("oe idle", {doe, coe, dout, cout}, 8'h0c); rdx(8'h72, 8'h0c);
      acc(8'h72, 8'h30, 1'b0); chk("oe drive", {doe, coe, dout, cout}, 8'h00); rdx(8'h72, 8'h30);
      hold = 1;
      acc(8'h72, 8'h33, 1'b0); rdx(8'h72, 8'h37);
      for (int i = 0; i < 8; i++) begin
         {sel, en} = {1'b0, i[2], i[2]};
         // each setting writes denominator 11h, which must come out unchanged under every post-divider code
         acc(8'h6d, {i[1:0], 6'h11}, 1'b0);
         ex = i[2] ? {i[0], i[1]} : {1'b0, i[1]};
         @(negedge clk_in) chk("post divide", {4'h0, pg, vd == 6'h11, sh}, {4'h0, i[2], 1'b1, ex});
      end
      repeat (3) @(negedge clk_in);
      if (q.size() != 0) num_errors++;
      complete_run;
   end
endmodule
